// file: pin_sync.sv
// Three-flop synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
module pin_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic init,
    // Pin and filtered level
    input  wire logic pin,
    output logic      level
);
    logic s1;           // First stage, read only by s2
    logic s2;           // Second stage
    logic s3;           // Third stage
    logic next_level;   // Filtered next value

    // Accept a change once stages two and three agree
    always_comb
    begin
        next_level = level;
        if (s2 == s3)
        begin
            next_level = s2;
        end
    end

    // Register the chain
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1    <= init;
            s2    <= init;
            s3    <= init;
            level <= init;
        end
        else
        begin
            s1    <= pin;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end
endmodule : pin_sync

// file: redriver_config_pkg.sv
// Constants for the redriver configuration-source selection block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package redriver_config_pkg;
    // Field widths and channel count
    localparam int EQ_W    = 3;
    localparam int GAIN_W  = 2;
    localparam int ADDR_W  = 3;
    localparam int NCH     = 4;
    // Reset values of configuration registers
    localparam logic [2:0] EQ_DEFAULT   = 3'h0;
    localparam logic [1:0] GAIN_DEFAULT = 2'h0;
    // Configuration source encodings
    typedef enum {SRC_STRAP, SRC_REG, SRC_EEPROM} source_t;
    // EEPROM loader states
    typedef enum {LD_IDLE, LD_BUSY, LD_DONE} load_state_t;
endpackage : redriver_config_pkg

// file: redriver_config_select.sv
// Configuration-source selection and control for a four-channel redriver.
// Assumes straps are asynchronous pins; register and EEPROM data come from
// the serial engine on the same clock.
`timescale 1ns/10ps
module redriver_config_select
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Strap and control pins
    input  wire logic        config_source_select,
    input  wire logic        config_source_float,
    input  wire logic        cable_present_n,
    input  wire logic [2:0]  eq_boost_straps,
    input  wire logic        gain_bit1_or_reg_reset_n,
    input  wire logic        gain_bit0_strap,
    input  wire logic [2:0]  addr_straps,
    // Register writes from the serial slave engine
    input  wire logic        reg_wr,
    input  wire logic [1:0]  reg_wr_chan,
    input  wire logic [2:0]  reg_wr_eq,
    input  wire logic [1:0]  reg_wr_gain,
    // EEPROM load result from the master engine
    input  wire logic        eeprom_load_done,
    input  wire logic        eeprom_load_ok,
    // Applied settings
    output logic [11:0]      chan_eq,
    output logic [7:0]       chan_gain,
    output logic             low_power,
    output logic [2:0]       slave_addr,
    output logic             master_mode,
    output logic             scl_oe,
    output logic             load_status
);
    // Synchronised pin levels
    logic       sel_s;
    logic       flt_s;
    logic       prs_s;
    logic       g1_s;
    logic       g0_s;
    logic [2:0] eq_s;
    logic [2:0] ad_s;

    pin_sync u_sel (.clk(clk), .reset(reset), .init(1'b0), .pin(config_source_select), .level(sel_s));
    pin_sync u_flt (.clk(clk), .reset(reset), .init(1'b0), .pin(config_source_float), .level(flt_s));
    pin_sync u_prs (.clk(clk), .reset(reset), .init(1'b1), .pin(cable_present_n), .level(prs_s));
    pin_sync u_g1  (.clk(clk), .reset(reset), .init(1'b1), .pin(gain_bit1_or_reg_reset_n), .level(g1_s));
    pin_sync u_g0  (.clk(clk), .reset(reset), .init(1'b1), .pin(gain_bit0_strap), .level(g0_s));

    // Multi-bit straps, one synchroniser each
    genvar gi;
    generate
        for (gi = 0; gi < redriver_config_pkg::EQ_W; gi++)
        begin : g_strap
            pin_sync u_eq (.clk(clk), .reset(reset), .init(1'b1), .pin(eq_boost_straps[gi]), .level(eq_s[gi]));
            pin_sync u_ad (.clk(clk), .reset(reset), .init(1'b1), .pin(addr_straps[gi]), .level(ad_s[gi]));
        end
    endgenerate

    // Current configuration source
    redriver_config_pkg::source_t src;
    always_comb
    begin
        if (flt_s)
        begin
            src = redriver_config_pkg::SRC_EEPROM;
        end
        else if (sel_s)
        begin
            src = redriver_config_pkg::SRC_REG;
        end
        else
        begin
            src = redriver_config_pkg::SRC_STRAP;
        end
    end

    // Shared pin is a register reset only outside strap mode
    logic reg_clear;
    assign reg_clear = (src != redriver_config_pkg::SRC_STRAP) && !g1_s;

    // Configuration registers per channel
    logic [11:0] reg_eq;
    logic [7:0]  reg_gain;
    logic [11:0] next_reg_eq;
    logic [7:0]  next_reg_gain;

    // Register write and reset path
    always_comb
    begin
        next_reg_eq   = reg_eq;
        next_reg_gain = reg_gain;
        if (reg_clear)
        begin
            next_reg_eq   = {redriver_config_pkg::NCH{redriver_config_pkg::EQ_DEFAULT}};
            next_reg_gain = {redriver_config_pkg::NCH{redriver_config_pkg::GAIN_DEFAULT}};
        end
        else if (reg_wr && src != redriver_config_pkg::SRC_STRAP)
        begin
            // Writes while in reset are dropped; host waits for release
            next_reg_eq[reg_wr_chan*3 +: 3]   = reg_wr_eq;
            next_reg_gain[reg_wr_chan*2 +: 2] = reg_wr_gain;
        end
    end

    // EEPROM load tracking
    redriver_config_pkg::load_state_t ld_state;
    redriver_config_pkg::load_state_t next_ld_state;
    logic next_load_status;

    // Loader status next state
    always_comb
    begin
        next_ld_state    = ld_state;
        next_load_status = load_status;
        case (ld_state)
            redriver_config_pkg::LD_IDLE:
            begin
                if (src == redriver_config_pkg::SRC_EEPROM)
                begin
                    next_ld_state    = redriver_config_pkg::LD_BUSY;
                    next_load_status = 1'b0;
                end
            end
            redriver_config_pkg::LD_BUSY:
            begin
                if (eeprom_load_done)
                begin
                    next_ld_state    = redriver_config_pkg::LD_DONE;
                    next_load_status = eeprom_load_ok;
                end
                else if (src != redriver_config_pkg::SRC_EEPROM)
                begin
                    next_ld_state = redriver_config_pkg::LD_IDLE;
                end
            end
            redriver_config_pkg::LD_DONE:
            begin
                if (src != redriver_config_pkg::SRC_EEPROM)
                begin
                    next_ld_state = redriver_config_pkg::LD_IDLE;
                end
            end
            default:
            begin
                next_ld_state = redriver_config_pkg::LD_IDLE;
            end
        endcase
    end

    // Applied outputs next values
    logic [11:0] next_chan_eq;
    logic [7:0]  next_chan_gain;
    always_comb
    begin
        if (src == redriver_config_pkg::SRC_STRAP)
        begin
            next_chan_eq   = {redriver_config_pkg::NCH{eq_s}};
            next_chan_gain = {redriver_config_pkg::NCH{g1_s, g0_s}};
        end
        else
        begin
            next_chan_eq   = reg_eq;
            next_chan_gain = reg_gain;
        end
    end

    // Register all state and outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reg_eq      <= {redriver_config_pkg::NCH{redriver_config_pkg::EQ_DEFAULT}};
            reg_gain    <= {redriver_config_pkg::NCH{redriver_config_pkg::GAIN_DEFAULT}};
            ld_state    <= redriver_config_pkg::LD_IDLE;
            load_status <= 1'b0;
            chan_eq     <= 12'h000;
            chan_gain   <= 8'h00;
            low_power   <= 1'b1;
            slave_addr  <= 3'h0;
            master_mode <= 1'b0;
            scl_oe      <= 1'b0;
        end
        else
        begin
            reg_eq      <= next_reg_eq;
            reg_gain    <= next_reg_gain;
            ld_state    <= next_ld_state;
            load_status <= next_load_status;
            chan_eq     <= next_chan_eq;
            chan_gain   <= next_chan_gain;
            low_power   <= prs_s;
            slave_addr  <= ad_s;
            master_mode <= (src == redriver_config_pkg::SRC_EEPROM);
            scl_oe      <= (src == redriver_config_pkg::SRC_EEPROM);
        end
    end

    // Assertions
    chk_low_power_follow: assert property (@(posedge clk) disable iff (reset)
        low_power == $past(prs_s)) else $error("low power not following cable input");
    chk_strap_eq_apply: assert property (@(posedge clk) disable iff (reset)
        (src == redriver_config_pkg::SRC_STRAP) |=> chan_eq == {4{$past(eq_s)}})
        else $error("strap eq not applied");
    chk_strap_gain_apply: assert property (@(posedge clk) disable iff (reset)
        (src == redriver_config_pkg::SRC_STRAP) |=> chan_gain == {4{$past(g1_s), $past(g0_s)}})
        else $error("strap gain not applied");
    chk_reg_source_apply: assert property (@(posedge clk) disable iff (reset)
        (src == redriver_config_pkg::SRC_REG) |=> chan_eq == $past(reg_eq))
        else $error("register eq not applied");
    chk_reg_reset_clear: assert property (@(posedge clk) disable iff (reset)
        reg_clear |=> reg_eq == 12'h000 && reg_gain == 8'h00)
        else $error("register reset ignored");
    chk_strap_no_clear: assert property (@(posedge clk) disable iff (reset)
        (src == redriver_config_pkg::SRC_STRAP && !g1_s) |=> reg_eq == $past(reg_eq) && reg_gain == $past(reg_gain))
        else $error("shared pin reset in strap mode");
    chk_load_status_ok: assert property (@(posedge clk) disable iff (reset)
        (ld_state == redriver_config_pkg::LD_BUSY && eeprom_load_done) |=> load_status == $past(eeprom_load_ok))
        else $error("load status wrong");
    // Output resets to zero while the strap chain resets high, so skip the first edge
    chk_addr_strap: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> slave_addr == $past(ad_s)) else $error("address strap not applied");
    chk_scl_master: assert property (@(posedge clk) disable iff (reset)
        scl_oe == master_mode && master_mode == $past(flt_s)) else $error("scl drive mismatch");
endmodule : redriver_config_select

// file: redriver_config_select_tb_top.sv
// Self-checking bench with a behavioural model of the selection block.
// Assumes the far-side model drives register writes and load results.
`timescale 1ns/10ps
module redriver_config_select_tb_top;
    // Design pins
    logic        clk = 1'b0, reset = 1'b1;
    logic        config_source_select = 1'b0, config_source_float = 1'b0;
    logic        cable_present_n = 1'b1, gain_bit1_or_reg_reset_n = 1'b1, gain_bit0_strap = 1'b0;
    logic [2:0]  eq_boost_straps = 3'h0, addr_straps = 3'h0;
    logic        reg_wr, eeprom_load_done, eeprom_load_ok;
    logic [1:0]  reg_wr_chan, reg_wr_gain;
    logic [2:0]  reg_wr_eq;
    logic [11:0] chan_eq;
    logic [7:0]  chan_gain;
    logic        low_power, master_mode, scl_oe, load_status;
    logic [2:0]  slave_addr;
    // Model state and counters
    logic [2:0]  m_eq [4];
    logic [1:0]  m_g [4];
    logic        m_ld = 1'b0;
    int          n_errors = 0, cmp_count = 0, cycles = 0, seed = 32, i;
    // 100 MHz clock
    always #5 clk = ~clk;
    redriver_config_select dut_u (.clk, .reset, .config_source_select, .config_source_float, .cable_present_n,
        .eq_boost_straps, .gain_bit1_or_reg_reset_n, .gain_bit0_strap, .addr_straps, .reg_wr, .reg_wr_chan,
        .reg_wr_eq, .reg_wr_gain, .eeprom_load_done, .eeprom_load_ok, .chan_eq, .chan_gain, .low_power,
        .slave_addr, .master_mode, .scl_oe, .load_status);
    redriver_far_engine far_u (.clk, .reg_wr, .reg_wr_chan, .reg_wr_eq, .reg_wr_gain, .eeprom_load_done,
        .eeprom_load_ok);
    // Verdict and end of run
    task automatic stop_test;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // Single comparison point
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            stop_test();
        end
    end
    // Wait for pins to pass the filter, then compare all outputs with the model
    task automatic settle_compare;
        logic strap;
        logic [11:0] e_eq;
        logic [7:0] e_g;
        repeat (6) @(negedge clk);
        strap = !config_source_float && !config_source_select;
        for (int c = 0; c < 4; c++)
        begin
            if (!strap && !gain_bit1_or_reg_reset_n)
                {m_eq[c], m_g[c]} = 5'h00;
            e_eq[3*c+:3] = strap ? eq_boost_straps : m_eq[c];
            e_g[2*c+:2] = strap ? {gain_bit1_or_reg_reset_n, gain_bit0_strap} : m_g[c];
        end
        check("chan_eq", chan_eq, e_eq);
        check("chan_gain", chan_gain, e_g);
        check("low_power", low_power, cable_present_n);
        check("slave_addr", slave_addr, addr_straps);
        check("master_mode", master_mode, config_source_float);
        check("scl_oe", scl_oe, config_source_float);
        check("load_status", load_status, m_ld);
    endtask : settle_compare
    // Random write through the far side; model keeps it only where accepted
    task automatic host_write(input int gap);
        logic [6:0] r;
        r = $random(seed);
        far_u.write_reg(r[1:0], r[4:2], r[6:5], gap);
        if ((config_source_float || config_source_select) && gain_bit1_or_reg_reset_n)
            {m_g[r[1:0]], m_eq[r[1:0]]} = r[6:2];
    endtask : host_write
    // Main sequence
    initial
    begin
        for (i = 0; i < 4; i++)
            {m_eq[i], m_g[i]} = 5'h00;
        repeat (4) @(negedge clk);
        check("reset low_power", low_power, 1'b1);
        reset = 1'b0;
        // Strap source: random straps, writes refused
        for (i = 0; i < 8; i++)
        begin
            {cable_present_n, eq_boost_straps, gain_bit1_or_reg_reset_n, gain_bit0_strap, addr_straps} = $random(seed);
            host_write(i % 3);
            settle_compare();
        end
        gain_bit1_or_reg_reset_n = 1'b1;
        settle_compare();
        // Register source: writes, cable toggles, clear, refused write
        config_source_select = 1'b1;
        settle_compare();
        for (i = 0; i < 10; i++)
        begin
            cable_present_n = $random(seed);
            host_write((i % 2) * 3);
            if (i == 7)
                gain_bit1_or_reg_reset_n = 1'b0;
            if (i == 8)
                gain_bit1_or_reg_reset_n = 1'b1;
            settle_compare();
        end
        // Contents survive strap use of the shared pin
        config_source_select = 1'b0;
        settle_compare();
        gain_bit1_or_reg_reset_n = 1'b0;
        settle_compare();
        gain_bit1_or_reg_reset_n = 1'b1;
        settle_compare();
        config_source_select = 1'b1;
        settle_compare();
        // EEPROM master: pass, leave, re-enter, fail
        for (i = 0; i < 2; i++)
        begin
            config_source_float = 1'b1;
            m_ld = 1'b0;
            settle_compare();
            far_u.finish_load(!i[0], 2 * i);
            m_ld = !i[0];
            host_write(1);
            settle_compare();
            config_source_float = 1'b0;
            settle_compare();
            // Result outside a load is ignored
            far_u.finish_load(i[0], 0);
            settle_compare();
        end
        stop_test();
    end
endmodule : redriver_config_select_tb_top

// file: redriver_far_engine.sv
// Far-side model: serial slave engine and EEPROM master engine.
// Assumes the block samples its inputs on the rising edge of clk.
`timescale 1ns/10ps
module redriver_far_engine
(
    // Clock
    input  wire logic  clk,
    // Register write towards the block
    output logic       reg_wr,
    output logic [1:0] reg_wr_chan,
    output logic [2:0] reg_wr_eq,
    output logic [1:0] reg_wr_gain,
    // EEPROM load result
    output logic       eeprom_load_done,
    output logic       eeprom_load_ok
);
    // Idle at time zero
    initial
    begin
        {reg_wr, reg_wr_chan, reg_wr_eq, reg_wr_gain} = 8'h55;
        {eeprom_load_done, eeprom_load_ok} = 2'h0;
    end
    // One write pulse after gap idle cycles, data inverted once released
    task automatic write_reg(input logic [1:0] ch, input logic [2:0] eq, input logic [1:0] g, input int gap);
        repeat (gap) @(negedge clk);
        {reg_wr, reg_wr_chan, reg_wr_eq, reg_wr_gain} = {1'b1, ch, eq, g};
        @(negedge clk);
        {reg_wr, reg_wr_chan, reg_wr_eq, reg_wr_gain} = {1'b0, ~ch, ~eq, ~g};
    endtask : write_reg
    // One load result pulse after gap cycles
    task automatic finish_load(input logic ok, input int gap);
        repeat (gap) @(negedge clk);
        {eeprom_load_done, eeprom_load_ok} = {1'b1, ok};
        @(negedge clk);
        {eeprom_load_done, eeprom_load_ok} = {1'b0, ~ok};
    endtask : finish_load
endmodule : redriver_far_engine
